// ===== hw/ued_pkg.sv
/*
 * Shared constants and types for the endpoint DMA handshake and
 * end-of-transfer block.
 * Assumes one 40 MHz device clock and pins synchronised inside the block.
 */
package ued_pkg;
    localparam int CNT_W = 16;
    localparam int EP_IDX_W = 4;
    localparam int EP_NUM = 16;
    localparam int DATA_W = 8;
    localparam int SYNC_W = DATA_W + 4;
    // bit positions inside the synchroniser word
    localparam int SY_ACK = 0;
    localparam int SY_EOT = 1;
    localparam int SY_WRN = 2;
    localparam int SY_RDN = 3;
    localparam int SY_DAT = 4;
    localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
    localparam logic [DATA_W-1:0] DAT_RST = 8'h00;
    localparam logic [EP_IDX_W-1:0] IDX_RST = 4'h0;
    localparam logic [SYNC_W-1:0] SYNC_RST = 12'h00C;

    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DONE} ued_state_t;
endpackage

// ===== hw/ued_sync.sv
/*
 * Two-flop synchroniser for a group of pin inputs.
 * Assumes each bit is an independent level; multi-bit words must be held
 * stable by the far side while they are sampled.
 */
`timescale 1ns/1ps
module ued_sync #(
    parameter int WIDTH = ued_pkg::SYNC_W,
    parameter logic [WIDTH-1:0] RST_VAL = ued_pkg::SYNC_RST
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic [WIDTH-1:0] i_d,
    output logic [WIDTH-1:0] o_q
);
    import ued_pkg::*;

    genvar g;
    // one stage pair per bit; first stage feeds only the second
    generate
        for (g = 0; g < WIDTH; g++)
        begin : g_bit
            logic meta_r;
            always_ff @(posedge i_clk or negedge i_rstn)
            begin
                if (!i_rstn)
                begin
                    meta_r <= RST_VAL[g];
                    o_q[g] <= RST_VAL[g];
                end
                else if (i_ce)
                begin
                    meta_r <= i_d[g];
                    o_q[g] <= meta_r;
                end
            end
        end
    endgenerate
endmodule

// ===== hw/ued_dma_term.sv
/*
 * DMA request/acknowledge handshake and end-of-transfer logic for the
 * endpoint FIFOs of a full-speed USB peripheral.
 * Assumes a fly-by DMA controller on the pins and endpoint FIFOs on the
 * same clock that accept single-cycle read, write, flush and validate pulses.
 */
`timescale 1ns/1ps
module ued_dma_term (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic i_dma_enable,
    input wire logic i_ack_only_mode_sel,
    input wire logic i_counter_end_enable,
    input wire logic i_short_packet_end_enable,
    input wire logic [ued_pkg::EP_IDX_W-1:0] i_dma_endpoint_index,
    input wire logic [ued_pkg::CNT_W-1:0] i_byte_count,
    input wire logic i_req_pol,
    input wire logic i_ack_pol,
    input wire logic i_eot_pol,
    input wire logic [ued_pkg::EP_NUM-1:0] i_endpoint_direction,
    input wire logic [ued_pkg::EP_NUM-1:0] i_ep_isochronous,
    input wire logic [ued_pkg::EP_NUM-1:0] i_ep_ready,
    input wire logic i_short_packet,
    input wire logic i_eop,
    input wire logic i_buf_last_byte,
    input wire logic [ued_pkg::DATA_W-1:0] i_fifo_rdata,
    input wire logic i_transfer_acknowledge,
    input wire logic i_end_of_transfer_in,
    input wire logic i_rd_n,
    input wire logic i_wr_n,
    input wire logic [ued_pkg::DATA_W-1:0] i_dbus,
    output logic o_transfer_request,
    output logic [ued_pkg::DATA_W-1:0] o_dbus,
    output logic o_dbus_oe,
    output logic o_fifo_rd,
    output logic o_fifo_wr,
    output logic [ued_pkg::DATA_W-1:0] o_fifo_wdata,
    output logic o_fifo_flush,
    output logic o_pkt_validate,
    output logic o_eot_irq,
    output logic o_dma_active,
    output logic o_transfer_dir,
    output logic [ued_pkg::EP_IDX_W-1:0] o_ack_ep_sel,
    output logic [ued_pkg::CNT_W-1:0] o_count_left
);
    import ued_pkg::*;

    logic [SYNC_W-1:0] sync_q;
    ued_state_t state_r;
    ued_state_t state_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [EP_IDX_W-1:0] idx_r;
    logic dir_in_r;
    logic iso_r;
    logic strobe_prev_r;
    logic eot_prev_r;
    logic short_pend_r;
    logic ack_act;
    logic eot_act;
    logic strobe;
    logic strobe_end;
    logic byte_done;
    logic last_byte;
    logic ext_end;
    logic cnt_end;
    logic short_end;
    logic eop_end;
    logic dis_end;
    logic any_end;

    // every pin goes through two flops before anything looks at it
    ued_sync #(
        .WIDTH(SYNC_W),
        .RST_VAL(SYNC_RST)
    ) u_sync (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_ce(i_ce),
        .i_d({i_dbus, i_rd_n, i_wr_n, i_end_of_transfer_in, i_transfer_acknowledge}),
        .o_q(sync_q)
    );

    // pin levels folded through their programmed polarity
    assign ack_act = ~(sync_q[SY_ACK] ^ i_ack_pol);
    assign eot_act = ~(sync_q[SY_EOT] ^ i_eot_pol);

    // acknowledge alone strobes in ack-only mode; otherwise it needs rd or wr
    always_comb
    begin
        if (i_ack_only_mode_sel)
            strobe = ack_act;
        else if (dir_in_r)
            strobe = ack_act & ~sync_q[SY_WRN];
        else
            strobe = ack_act & ~sync_q[SY_RDN];
    end

    // a byte counts when the strobe closes, so data has settled on the bus
    assign strobe_end = strobe_prev_r & ~strobe;
    assign byte_done = (state_r == ST_RUN) & strobe_end;
    assign last_byte = byte_done & (cnt_r == CNT_ONE);

    // end sources, only meaningful while running
    assign ext_end = (state_r == ST_RUN) & eot_act & ~eot_prev_r;
    assign cnt_end = i_counter_end_enable & last_byte;
    always_comb
    begin
        short_end = 1'b0;
        if (i_short_packet_end_enable && !iso_r && state_r == ST_RUN)
        begin
            if (dir_in_r)
                short_end = last_byte & ~i_buf_last_byte;
            else
                short_end = short_pend_r & ~i_ep_ready[idx_r];
        end
    end
    assign eop_end = (state_r == ST_RUN) & iso_r & i_eop;
    assign dis_end = (state_r == ST_RUN) & ~i_dma_enable;
    assign any_end = ext_end | cnt_end | short_end | eop_end;

    // transfer state: idle, running, or ended awaiting a fresh enable
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE:
            begin
                if (i_dma_enable)
                    state_nxt = ST_RUN;
            end
            ST_RUN:
            begin
                if (dis_end)
                    state_nxt = ST_IDLE;
                else if (any_end)
                    state_nxt = ST_DONE;
            end
            ST_DONE:
            begin
                if (!i_dma_enable)
                    state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            state_r <= ST_IDLE;
        else if (i_ce)
            state_r <= state_nxt;
    end

    // endpoint choice is frozen at enable; one index means one endpoint
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            idx_r <= IDX_RST;
            dir_in_r <= 1'b0;
            iso_r <= 1'b0;
        end
        else if (i_ce && state_r == ST_IDLE && i_dma_enable)
        begin
            idx_r <= i_dma_endpoint_index;
            dir_in_r <= i_endpoint_direction[i_dma_endpoint_index];
            iso_r <= i_ep_isochronous[i_dma_endpoint_index];
        end
    end

    // byte counter loads on enable and counts down per strobe
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            cnt_r <= CNT_RST;
        else if (i_ce)
        begin
            if (state_r == ST_IDLE && i_dma_enable)
                cnt_r <= i_byte_count;
            else if (byte_done && cnt_r != CNT_RST)
                cnt_r <= cnt_r - CNT_ONE;
        end
    end

    // edge history for strobe and end pin
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            strobe_prev_r <= 1'b0;
            eot_prev_r <= 1'b0;
        end
        else if (i_ce)
        begin
            strobe_prev_r <= strobe;
            eot_prev_r <= eot_act;
        end
    end

    // short packet seen on OUT; a new arrival wins over the clear at load
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            short_pend_r <= 1'b0;
        else if (i_ce)
        begin
            if (i_short_packet)
                short_pend_r <= 1'b1;
            else if (state_r == ST_IDLE)
                short_pend_r <= 1'b0;
        end
    end

    // request pin; dropped during a strobe so each byte is asked for anew
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            o_transfer_request <= 1'b0;
        else if (i_ce)
            o_transfer_request <= i_req_pol ~^
                ((state_r == ST_RUN) & i_ep_ready[idx_r] & ~strobe & ~any_end & i_dma_enable);
    end

    // data bus drive for OUT reads; IN writes capture the bus on every cycle the strobe is active
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_dbus <= DAT_RST;
            o_dbus_oe <= 1'b0;
            o_fifo_wdata <= DAT_RST;
        end
        else if (i_ce)
        begin
            o_dbus <= i_fifo_rdata;
            o_dbus_oe <= (state_r == ST_RUN) & strobe & ~dir_in_r;
            if (strobe)
                o_fifo_wdata <= sync_q[SY_DAT +: DATA_W];
        end
    end

    // FIFO strobes, flush and validate pulses
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_fifo_rd <= 1'b0;
            o_fifo_wr <= 1'b0;
            o_fifo_flush <= 1'b0;
            o_pkt_validate <= 1'b0;
        end
        else if (i_ce)
        begin
            o_fifo_rd <= byte_done & ~dir_in_r;
            o_fifo_wr <= byte_done & dir_in_r;
            // flush acts on the active buffer only; the other half is left
            o_fifo_flush <= ext_end & ~dis_end & ~dir_in_r;
            o_pkt_validate <= any_end & ~dis_end & dir_in_r;
        end
    end

    // status outputs; disable-caused stops stay silent
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_eot_irq <= 1'b0;
            o_dma_active <= 1'b0;
            o_transfer_dir <= 1'b0;
            o_ack_ep_sel <= IDX_RST;
            o_count_left <= CNT_RST;
        end
        else if (i_ce)
        begin
            o_eot_irq <= any_end & ~dis_end;
            o_dma_active <= (state_nxt == ST_RUN);
            o_transfer_dir <= dir_in_r;
            if (ack_act)
                o_ack_ep_sel <= idx_r;
            o_count_left <= cnt_r;
        end
    end

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn || !i_ce);

    a_req_after_end: assert property ((state_r == ST_DONE) |=> (o_transfer_request != $past(i_req_pol)))
        else $error("request active after end of transfer");
    a_count_load: assert property ((state_r == ST_IDLE && i_dma_enable) |=> (cnt_r == $past(i_byte_count)))
        else $error("counter not loaded at enable");
    a_out_flush: assert property ((ext_end && !dis_end && !dir_in_r) |=> o_fifo_flush ##1 !o_fifo_flush)
        else $error("OUT end input did not flush once");
    a_in_validate: assert property ((ext_end && !dis_end && dir_in_r) |=> (o_pkt_validate && !o_fifo_flush))
        else $error("IN end input did not validate packet");
    a_disable_silent: assert property (dis_end |=> (!o_eot_irq && state_r == ST_IDLE))
        else $error("enable clear raised interrupt or kept running");
    a_counter_end: assert property ((state_r == ST_RUN && i_counter_end_enable && last_byte && i_dma_enable)
        |=> (state_r == ST_DONE) ##1 (o_transfer_request != $past(i_req_pol)))
        else $error("counter completion did not end transfer");
    a_ack_only_byte: assert property ((i_ack_only_mode_sel && byte_done && !dir_in_r) |=> o_fifo_rd)
        else $error("acknowledge strobe did not read a byte");
    a_req_ready: assert property ((state_r == ST_RUN && i_dma_enable && i_ep_ready[idx_r] && !strobe && !any_end)
        |=> (o_transfer_request == $past(i_req_pol)))
        else $error("request not raised for ready endpoint");
    a_iso_eop_end: assert property ((eop_end && !dis_end) |=> (state_r == ST_DONE && o_eot_irq))
        else $error("end-of-packet did not end iso transfer");
    a_dir_follow: assert property ((state_r == ST_RUN) |=> (o_transfer_dir == $past(dir_in_r)))
        else $error("direction output does not follow endpoint");

    c_run_to_done: cover property ((state_r == ST_RUN) ##[1:50] (state_r == ST_DONE));
    c_ext_end: cover property (ext_end && !dis_end);
    c_byte_in_ack_only: cover property (i_ack_only_mode_sel && byte_done && dir_in_r);
    c_short_out: cover property (short_end && !dir_in_r);
endmodule

// ===== bench/ued_dma_host.sv
/* fly-by dma controller model for the far side of the dma pins.
   assumes the bench calls move and end_pulse from its main sequence. */
`timescale 1ns/1ps
module ued_dma_host (
    input wire logic i_clk,
    input wire logic i_req,
    input wire logic i_req_pol,
    input wire logic i_ack_pol,
    input wire logic i_eot_pol,
    input wire logic i_dir_in,
    output logic o_ack,
    output logic o_eot,
    output logic o_rd_n,
    output logic o_wr_n,
    output logic [7:0] o_dbus
);
    logic ack_on = 1'b0;
    logic eot_on = 1'b0;
    // pin levels follow the programmed polarity
    assign o_ack = ack_on ~^ i_ack_pol;
    assign o_eot = eot_on ~^ i_eot_pol;
    initial
    begin
        o_rd_n = 1'b1;
        o_wr_n = 1'b1;
        o_dbus = 8'h00;
    end
    // one byte: wait for request, strobe with ack, hold long enough for sync
    task automatic move(input logic [7:0] d, input logic use_rw, output logic ok);
        int n;
        begin
            n = 0;
            while (i_req !== i_req_pol && n < 40)
            begin
                @(negedge i_clk);
                n++;
            end
            ok = (n < 40);
            if (ok)
            begin
                o_dbus = d;
                ack_on = 1'b1;
                if (use_rw)
                begin
                    o_wr_n = ~i_dir_in;
                    o_rd_n = i_dir_in;
                end
                repeat (4) @(negedge i_clk);
                ack_on = 1'b0;
                o_rd_n = 1'b1;
                o_wr_n = 1'b1;
                o_dbus = ~d; // released bus must not keep the old byte
                repeat (5) @(negedge i_clk);
            end
        end
    endtask
    // external end: held over several clocks so the synchroniser sees it
    task automatic end_pulse();
        begin
            eot_on = 1'b1;
            repeat (4) @(negedge i_clk);
            eot_on = 1'b0;
            repeat (4) @(negedge i_clk);
        end
    endtask
endmodule

// ===== bench/tb_ued_dma_term.sv
/* self-checking bench for the endpoint dma handshake block.
   assumes the host model drives the pins and the bench the config ports. */
`timescale 1ns/1ps
module tb_ued_dma_term;
    logic i_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic en = 0, mode = 1, cen = 0, sen = 0, rp = 1, ap = 1, ep = 1;
    logic shp = 0, eop = 0, lastb = 1, ce = 1, ok;
    logic [3:0] idx = 4'h0;
    logic [15:0] cnt = 16'h0000, dir = 16'h0020, iso = 16'h0000, rdy = 16'h0024;
    logic ack, end_of_transfer_in, rd_n, wr_n, req, oe, act, tdir, f_rd, f_wr, fl, val, irq;
    logic [7:0] h_db, d_db, bus, wd, rd_seen;
    logic [3:0] sel;
    logic [15:0] left;
    logic [7:0] wq[$];
    int pc[5];
    int errors = 0;
    int n_tests = 0;
    int cyc = 0;
    // two-way data bus resolved from the device enable
    assign bus = oe ? d_db : h_db;
    always #12.5 i_clk = ~i_clk;
    ued_dma_term u_ued_dma_term (.i_clk(i_clk), .i_rstn(i_rstn), .i_ce(ce), .i_dma_enable(en),
        .i_ack_only_mode_sel(mode), .i_counter_end_enable(cen), .i_short_packet_end_enable(sen),
        .i_dma_endpoint_index(idx), .i_byte_count(cnt), .i_req_pol(rp), .i_ack_pol(ap),
        .i_eot_pol(ep), .i_endpoint_direction(dir), .i_ep_isochronous(iso), .i_ep_ready(rdy),
        .i_short_packet(shp), .i_eop(eop), .i_buf_last_byte(lastb), .i_fifo_rdata(8'h5A),
        .i_transfer_acknowledge(ack), .i_end_of_transfer_in(end_of_transfer_in), .i_rd_n(rd_n), .i_wr_n(wr_n),
        .i_dbus(bus), .o_transfer_request(req), .o_dbus(d_db), .o_dbus_oe(oe), .o_fifo_rd(f_rd),
        .o_fifo_wr(f_wr), .o_fifo_wdata(wd), .o_fifo_flush(fl), .o_pkt_validate(val),
        .o_eot_irq(irq), .o_dma_active(act), .o_transfer_dir(tdir), .o_ack_ep_sel(sel),
        .o_count_left(left));
    ued_dma_host u_ued_dma_host (.i_clk(i_clk), .i_req(req), .i_req_pol(rp), .i_ack_pol(ap),
        .i_eot_pol(ep), .i_dir_in(tdir), .o_ack(ack), .o_eot(end_of_transfer_in), .o_rd_n(rd_n), .o_wr_n(wr_n),
        .o_dbus(h_db));
    // pulse monitor: rd, wr, flush, validate, irq
    always @(posedge i_clk)
    begin
        pc[0] += f_rd;
        pc[1] += f_wr;
        pc[2] += fl;
        pc[3] += val;
        pc[4] += irq;
        if (f_wr)
            wq.push_back(wd);
        if (oe)
            rd_seen = d_db;
    end
    // hang guard, well above the fewer than two hundred cycles the tests need
    always @(posedge i_clk)
    begin
        cyc++;
        if (cyc == 8000)
        begin
            errors++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        begin
            if (errors == 0 && n_tests > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        begin
            n_tests++;
            if (got !== exp)
            begin
                errors++;
                $display("[FAIL] %s exp %h got %h", nm, exp, got);
            end
        end
    endtask
    task automatic go(input logic [3:0] ix, input logic [15:0] c);
        begin
            @(negedge i_clk);
            idx = ix;
            cnt = c;
            en = 1'b1;
            pc = '{default: 0};
            wq.delete();
            repeat (3) @(negedge i_clk);
        end
    endtask
    task automatic stop();
        begin
            @(negedge i_clk);
            en = 1'b0;
            repeat (3) @(negedge i_clk);
        end
    endtask
    initial
    begin
        repeat (6) @(negedge i_clk);
        i_rstn = 1'b1;
        repeat (2) @(negedge i_clk);
        chk("req_idle", 16'h0000, {15'h0, req});
        // in bulk, ack-only, counter end after three bytes
        cen = 1'b1;
        go(4'h5, 16'h0003);
        chk("count_load", 16'h0003, left);
        chk("dir_in", 16'h0001, {15'h0, tdir});
        for (int i = 0; i < 3; i++)
        begin
            u_ued_dma_host.move(8'hA0 + 8'(i), 1'b0, ok);
            chk("req_seen", 16'h0001, {15'h0, ok});
        end
        chk("ack_sel", 16'h0005, {12'h0, sel});
        chk("wr_count", 16'h0003, 16'(pc[1]));
        chk("wdata_last", 16'h00A2, {8'h0, wq[$]});
        chk("irq_cnt", 16'h0001, 16'(pc[4]));
        chk("validate", 16'h0001, 16'(pc[3]));
        chk("count_end", 16'h0000, left);
        repeat (10) @(negedge i_clk);
        chk("req_held_off", 16'h0000, {15'h0, req});
        // out bulk, strobe mode, all pins active low, external end
        // polarity flips only while ended, so the sync glitch cannot count a byte
        mode = 1'b0;
        rp = 1'b0;
        ap = 1'b0;
        ep = 1'b0;
        cen = 1'b0;
        stop();
        go(4'h2, 16'h000A);
        chk("dir_out", 16'h0000, {15'h0, tdir});
        u_ued_dma_host.move(8'h11, 1'b0, ok);
        chk("no_rw_no_byte", 16'h0000, 16'(pc[0]));
        u_ued_dma_host.move(8'h11, 1'b1, ok);
        u_ued_dma_host.move(8'h22, 1'b1, ok);
        chk("rd_count", 16'h0002, 16'(pc[0]));
        chk("rd_data", 16'h005A, {8'h0, rd_seen});
        u_ued_dma_host.end_pulse();
        chk("flush", 16'h0001, 16'(pc[2]));
        chk("eot_irq", 16'h0001, 16'(pc[4]));
        chk("no_validate", 16'h0000, 16'(pc[3]));
        chk("req_off_low", 16'h0001, {15'h0, req});
        mode = 1'b1;
        rp = 1'b1;
        ap = 1'b1;
        ep = 1'b1;
        cen = 1'b1;
        stop();
        // enable clear mid-transfer ends quietly, but not while frozen
        go(4'h5, 16'h000A);
        ce = 1'b0;
        @(negedge i_clk);
        en = 1'b0;
        repeat (3) @(negedge i_clk);
        chk("ce_freeze", 16'h0001, {15'h0, act});
        ce = 1'b1;
        stop();
        chk("clr_irq", 16'h0000, 16'(pc[4] + pc[3]));
        chk("clr_active", 16'h0000, {15'h0, act});
        // isochronous OUT ends on end-of-packet, the preferred source there
        iso = 16'h0004;
        go(4'h2, 16'h000A);
        eop = 1'b1;
        @(negedge i_clk);
        eop = 1'b0;
        repeat (3) @(negedge i_clk);
        chk("iso_irq", 16'h0001, 16'(pc[4]));
        chk("iso_active", 16'h0000, {15'h0, act});
        stop();
        iso = 16'h0000;
        // out bulk short packet: move its byte, then stop
        cen = 1'b0;
        sen = 1'b1;
        go(4'h2, 16'h0032);
        u_ued_dma_host.move(8'h33, 1'b0, ok);
        shp = 1'b1;
        rdy = 16'h0020;
        @(negedge i_clk);
        shp = 1'b0;
        repeat (4) @(negedge i_clk);
        chk("short_out_irq", 16'h0001, 16'(pc[4]));
        chk("short_out_rd", 16'h0001, 16'(pc[0]));
        stop();
        rdy = 16'h0024;
        // in bulk short: count hits zero with the buffer not full
        lastb = 1'b0;
        go(4'h5, 16'h0001);
        u_ued_dma_host.move(8'h44, 1'b0, ok);
        chk("short_in_irq", 16'h0001, 16'(pc[4]));
        chk("short_in_wr", 16'h0001, 16'(pc[1]));
        stop();
        wrap_up();
    end
endmodule
